// ---- rtl/dsd_pkg.sv ----
// package for the drive status display sequencer
`default_nettype none
package dsd_pkg;
    // drive variants
    typedef enum logic [1:0] {
        DSD_VAR_BASE,
        DSD_VAR_FIELDBUS,
        DSD_VAR_FIBER
    } dsd_variant_t;

    // fault codes shown after the letter E
    localparam logic [7:0] DSD_CODE_E01 = 8'h01;
    localparam logic [7:0] DSD_CODE_E02 = 8'h02;
    localparam logic [7:0] DSD_CODE_E03 = 8'h03;

    // seven-segment patterns, bit 0 = segment a ... bit 6 = segment g
    localparam logic [6:0] DSD_SEG_BLANK = 7'h00;
    localparam logic [6:0] DSD_SEG_E = 7'h79;
    localparam logic [6:0] DSD_SEG_L = 7'h38;
    localparam logic [6:0] DSD_SEG_4 = 7'h66;
    localparam logic [6:0] DSD_SEG_A = 7'h01;
    localparam logic [6:0] DSD_SEG_G = 7'h40;
    localparam logic [6:0] DSD_SEG_D = 7'h08;

    // outer ring of six segments a..f, and the run path of a..f then g twice
    localparam int DSD_RING_LEN = 6;
    localparam int DSD_RUN_LEN = 8;

    // absolute feedback travel limit in revolutions
    localparam logic [15:0] DSD_ABS_REV_LIMIT = 16'h07FF;

    // display timing
    localparam int DSD_CLK_HZ = 20_000_000;
    localparam int DSD_STEP_MS = 100;
    localparam int DSD_STEP_CYC = DSD_CLK_HZ / 1000 * DSD_STEP_MS;
    localparam int DSD_BLINK_MS = 500;
    localparam int DSD_BLINK_CYC = DSD_CLK_HZ / 1000 * DSD_BLINK_MS;

    // fault inputs grouped
    typedef struct packed {
        logic abs_fb;          // absolute feedback fitted
        logic nv_wear_over;    // motion range and homing count past limit
        logic rollover_en;     // machine cycle rollover enabled
        logic [15:0] half_cycle; // half cycle length per millisecond
        logic [15:0] vel_cmd;  // magnitude, counts per millisecond
        logic [15:0] vel_fb;   // magnitude, counts per millisecond
        logic [15:0] rev_from_home; // magnitude, revolutions
        logic rev_neg;         // unused sign, kept for the caller
    } dsd_fault_in_t;
endpackage
`default_nettype wire

// ---- rtl/dsd_status_display.sv ----
// status display sequencer: ready, overtravel and fault patterns
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - display only while logic power is present
// - base variant runs outer segments full circle
// - fieldbus variant runs a circular run pattern
// - fiber variant shows a steady digit 4
// - fault shows E then each digit singly
// - fault sequence repeats until fault clears
// - overtravel blinks L and restricts motion
// - E01 raised on nonvolatile wear limit
// - E01 cannot be cleared
// - E02 when velocity exceeds half cycle
// - E03 beyond 2047 revolutions from home
module dsd_status_display
    import dsd_pkg::*;
#(
    parameter int STEP_CYC = DSD_STEP_CYC,
    parameter int BLINK_CYC = DSD_BLINK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // drive state
    input wire logic logic_pwr,
    input wire dsd_variant_t variant,
    input wire logic overtravel,
    input wire dsd_fault_in_t fault_in,
    input wire logic fault_clear,
    // indication
    output logic [6:0] seg,
    output logic motion_restrict,
    output logic fault_active,
    output logic [7:0] fault_code
);
    typedef enum logic [2:0] {
        DSD_ST_READY, DSD_ST_OVT, DSD_ST_LET_E, DSD_ST_GAP0,
        DSD_ST_TENS, DSD_ST_GAP1, DSD_ST_ONES, DSD_ST_GAP2
    } dsd_state_t;

    dsd_state_t state_r, state_nxt;
    logic [31:0] tick_cnt_r;
    logic [31:0] blink_cnt_r;
    logic blink_r;
    logic [2:0] ring_r;
    logic e01_r, e02_r, e03_r;
    logic [6:0] seg_nxt;

    // fault detection terms
    wire logic det_e01 = fault_in.abs_fb & fault_in.nv_wear_over;
    wire logic det_e02 = fault_in.rollover_en &
        ((fault_in.vel_cmd > fault_in.half_cycle) |
         (fault_in.vel_fb > fault_in.half_cycle));
    wire logic det_e03 = fault_in.abs_fb &
        (fault_in.rev_from_home > DSD_ABS_REV_LIMIT);
    wire logic any_fault = e01_r | e02_r | e03_r;
    wire logic step = (tick_cnt_r == 32'(STEP_CYC - 1));
    wire logic blink_tick = (blink_cnt_r == 32'(BLINK_CYC - 1));
    wire logic [7:0] code_w = e01_r ? DSD_CODE_E01 :
        (e02_r ? DSD_CODE_E02 : (e03_r ? DSD_CODE_E03 : 8'h00));

    // sticky faults; the E01 latch ignores clearing, set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            e01_r <= 1'b0;
            e02_r <= 1'b0;
            e03_r <= 1'b0;
        end else begin
            e01_r <= e01_r | det_e01;
            e02_r <= det_e02 | (e02_r & ~fault_clear);
            e03_r <= det_e03 | (e03_r & ~fault_clear);
        end
    end

    // step and blink timebases
    always_ff @(posedge clk) begin
        if (srst || step) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else if (blink_tick) begin
            blink_cnt_r <= 32'h0;
            blink_r <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h1;
        end
    end

    // ring position for the running ready patterns
    always_ff @(posedge clk) begin
        if (srst) begin
            ring_r <= 3'h0;
        end else if (step) begin
            ring_r <= (variant == DSD_VAR_FIELDBUS) ?
                ((ring_r == 3'(DSD_RUN_LEN - 1)) ? 3'h0 : ring_r + 3'h1) :
                ((ring_r >= 3'(DSD_RING_LEN - 1)) ? 3'h0 : ring_r + 3'h1);
        end
    end

    // display sequence; phases advance on each blink tick, so all but the first E after a fault appears last one blink period
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DSD_ST_READY, DSD_ST_OVT: begin
                if (any_fault) begin
                    state_nxt = DSD_ST_LET_E;
                end else if (overtravel) begin
                    state_nxt = DSD_ST_OVT;
                end else begin
                    state_nxt = DSD_ST_READY;
                end
            end
            default: begin
                if (!any_fault) begin
                    state_nxt = DSD_ST_READY;
                end else if (blink_tick) begin
                    // wraps from the last gap back to E
                    state_nxt = (state_r == DSD_ST_GAP2) ?
                        DSD_ST_LET_E : dsd_state_t'(state_r + 3'h1);
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= DSD_ST_READY;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ready glyph per variant
    wire logic [6:0] ring_seg = 7'(7'h01 << ring_r);
    wire logic [6:0] run_seg = (ring_r == 3'h6) ? DSD_SEG_G :
        (ring_r == 3'h7) ? DSD_SEG_G : 7'(7'h01 << ring_r[2:0]);
    wire logic [6:0] ready_seg = (variant == DSD_VAR_FIBER) ? DSD_SEG_4 :
        (variant == DSD_VAR_FIELDBUS) ? run_seg : ring_seg;

    // digit decode for one nibble of the fault code
    function automatic logic [6:0] dsd_digit(input logic [3:0] d);
        case (d)
            4'h0: dsd_digit = 7'h3F;
            4'h1: dsd_digit = 7'h06;
            4'h2: dsd_digit = 7'h5B;
            4'h3: dsd_digit = 7'h4F;
            4'h4: dsd_digit = 7'h66;
            4'h5: dsd_digit = 7'h6D;
            4'h6: dsd_digit = 7'h7D;
            4'h7: dsd_digit = 7'h07;
            4'h8: dsd_digit = 7'h7F;
            4'h9: dsd_digit = 7'h6F;
            default: dsd_digit = DSD_SEG_BLANK;
        endcase
    endfunction

    // glyph selection; gaps keep repeated digits visibly separate
    always_comb begin
        case (state_nxt)
            DSD_ST_READY: seg_nxt = ready_seg;
            DSD_ST_OVT: seg_nxt = blink_r ? DSD_SEG_L : DSD_SEG_BLANK;
            DSD_ST_LET_E: seg_nxt = DSD_SEG_E;
            DSD_ST_TENS: seg_nxt = dsd_digit(code_w[7:4]);
            DSD_ST_ONES: seg_nxt = dsd_digit(code_w[3:0]);
            default: seg_nxt = DSD_SEG_BLANK;
        endcase
        if (!logic_pwr) begin
            seg_nxt = DSD_SEG_BLANK;
        end
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            seg <= DSD_SEG_BLANK;
            motion_restrict <= 1'b0;
            fault_active <= 1'b0;
            fault_code <= 8'h00;
        end else begin
            seg <= seg_nxt;
            motion_restrict <= overtravel;
            fault_active <= any_fault;
            fault_code <= code_w;
        end
    end

    // checks
    a_e01_sticky: assert property (@(posedge clk) disable iff (srst)
        e01_r |=> e01_r) else $error("E01 fault was cleared");
    a_e01_raise: assert property (@(posedge clk) disable iff (srst)
        det_e01 |=> e01_r) else $error("E01 not raised");
    a_e02_raise: assert property (@(posedge clk) disable iff (srst)
        det_e02 |=> e02_r) else $error("E02 not raised");
    a_e03_raise: assert property (@(posedge clk) disable iff (srst)
        det_e03 |=> ##1 fault_active) else $error("E03 not shown");
    a_dark_unpowered: assert property (@(posedge clk) disable iff (srst)
        !logic_pwr |=> seg == DSD_SEG_BLANK) else $error("lit unpowered");
    a_fiber_four: assert property (@(posedge clk) disable iff (srst)
        (logic_pwr && variant == DSD_VAR_FIBER && state_nxt == DSD_ST_READY)
        |=> seg == DSD_SEG_4) else $error("fiber ready not 4");
    a_fault_first: assert property (@(posedge clk) disable iff (srst)
        (any_fault && state_r == DSD_ST_OVT) |=> state_r == DSD_ST_LET_E)
        else $error("fault lost priority");
    a_fault_repeat: assert property (@(posedge clk) disable iff (srst)
        (state_r == DSD_ST_GAP2 && blink_tick && any_fault)
        |=> state_r == DSD_ST_LET_E) else $error("sequence not repeated");
    a_ovt_restrict: assert property (@(posedge clk) disable iff (srst)
        overtravel |=> motion_restrict) else $error("no restriction");
    a_ring_moves: assert property (@(posedge clk) disable iff (srst)
        (step && variant == DSD_VAR_BASE && ring_r < 3'h5)
        |=> ring_r == $past(ring_r) + 3'h1) else $error("ring stuck");
    a_run_wraps: assert property (@(posedge clk) disable iff (srst)
        (step && variant == DSD_VAR_FIELDBUS && ring_r == 3'h7)
        |=> ring_r == 3'h0) else $error("run not circular");
    a_digits_apart: assert property (@(posedge clk) disable iff (srst)
        (state_r == DSD_ST_TENS && blink_tick && any_fault)
        |=> state_r == DSD_ST_GAP1) else $error("digits together");
    a_phase_hold: assert property (@(posedge clk) disable iff (srst)
        (state_r == DSD_ST_TENS && !blink_tick && any_fault)
        |=> state_r == DSD_ST_TENS) else $error("digit phase cut short");
    a_show_e: assert property (@(posedge clk) disable iff (srst)
        (logic_pwr && state_nxt == DSD_ST_LET_E)
        |=> seg == DSD_SEG_E) else $error("letter E not shown");
    a_gap_dark: assert property (@(posedge clk) disable iff (srst)
        (state_nxt == DSD_ST_GAP0 || state_nxt == DSD_ST_GAP1 ||
         state_nxt == DSD_ST_GAP2) |=> seg == DSD_SEG_BLANK)
        else $error("gap not dark");

    // latch behaviour: a cleared cause lets go, a held one stays
    a_e02_clear: assert property (@(posedge clk) disable iff (srst)
        (!det_e02 && fault_clear) |=> !e02_r)
        else $error("E02 not cleared");
    a_e03_clear: assert property (@(posedge clk) disable iff (srst)
        (!det_e03 && fault_clear) |=> !e03_r)
        else $error("E03 not cleared");
    a_e02_hold: assert property (@(posedge clk) disable iff (srst)
        (e02_r && !fault_clear) |=> e02_r)
        else $error("E02 dropped by itself");
    a_e03_hold: assert property (@(posedge clk) disable iff (srst)
        (e03_r && !fault_clear) |=> e03_r)
        else $error("E03 dropped by itself");
    a_e03_latch: assert property (@(posedge clk) disable iff (srst)
        det_e03 |=> e03_r) else $error("E03 not latched");
    a_fault_flag: assert property (@(posedge clk) disable iff (srst)
        any_fault |=> fault_active) else $error("fault flag missing");
    a_fault_flag_off: assert property (@(posedge clk) disable iff (srst)
        !any_fault |=> !fault_active) else $error("fault flag stuck");
    a_fault_exit: assert property (@(posedge clk) disable iff (srst)
        (!any_fault && state_r != DSD_ST_READY && state_r != DSD_ST_OVT)
        |=> state_r == DSD_ST_READY) else $error("sequence outlived fault");

    // reported code follows the fixed priority of the latches
    a_code_e01: assert property (@(posedge clk) disable iff (srst)
        e01_r |=> fault_code == DSD_CODE_E01)
        else $error("wrong code for E01");
    a_code_e02: assert property (@(posedge clk) disable iff (srst)
        (e02_r && !e01_r) |=> fault_code == DSD_CODE_E02)
        else $error("wrong code for E02");
    a_code_e03: assert property (@(posedge clk) disable iff (srst)
        (e03_r && !e01_r && !e02_r) |=> fault_code == DSD_CODE_E03)
        else $error("wrong code for E03");

    // overtravel indication and the state it lives in
    a_restrict_off: assert property (@(posedge clk) disable iff (srst)
        !overtravel |=> !motion_restrict) else $error("restriction held");
    a_l_glyph: assert property (@(posedge clk) disable iff (srst)
        (logic_pwr && state_nxt == DSD_ST_OVT && blink_r)
        |=> seg == DSD_SEG_L) else $error("letter L not shown");
    a_blink_toggle: assert property (@(posedge clk) disable iff (srst)
        blink_tick |=> blink_r != $past(blink_r))
        else $error("blink phase stuck");
    a_ovt_enter: assert property (@(posedge clk) disable iff (srst)
        ((state_r == DSD_ST_READY || state_r == DSD_ST_OVT) &&
         !any_fault && overtravel) |=> state_r == DSD_ST_OVT)
        else $error("overtravel lost to ready");
    a_ready_stay: assert property (@(posedge clk) disable iff (srst)
        (state_r == DSD_ST_READY && !any_fault && !overtravel)
        |=> state_r == DSD_ST_READY) else $error("ready left idly");

    // ready patterns: one outer segment at a time, run path ends on g
    a_base_one_seg: assert property (@(posedge clk) disable iff (srst)
        (logic_pwr && variant == DSD_VAR_BASE && state_nxt == DSD_ST_READY)
        |=> ($onehot(seg) && !seg[6])) else $error("ring glyph wrong");
    a_base_wrap: assert property (@(posedge clk) disable iff (srst)
        (step && variant == DSD_VAR_BASE && ring_r == 3'h5)
        |=> ring_r == 3'h0) else $error("ring not closed");
    a_run_middle: assert property (@(posedge clk) disable iff (srst)
        (logic_pwr && variant == DSD_VAR_FIELDBUS &&
         state_nxt == DSD_ST_READY && ring_r[2:1] == 2'h3)
        |=> seg == DSD_SEG_G) else $error("run path misses g");
endmodule // dsd_status_display

`default_nettype wire

// ---- verification/dsd_operator_model.sv ----
// operator model: reads glyphs off the status display
`timescale 1ns/1ps
`default_nettype none
module dsd_operator_model
    import dsd_pkg::*;
(
    // clock and restart of the reading
    input wire logic clk,
    input wire logic clr,
    // display as seen by the operator
    input wire logic [6:0] seg,
    // what the operator has read
    output logic [6:0] seg_or,
    output logic [6:0] tens,
    output logic [6:0] ones,
    output int rd_cnt,
    output int l_cnt,
    output int chg_cnt
);
    logic [6:0] last = 7'h00;
    logic [1:0] idx = 2'h0;
    wire logic fresh = (seg != last) && (seg != DSD_SEG_BLANK);

    // a glyph counts once per appearance; the blank gap splits repeats
    always @(posedge clk) begin
        last <= seg;
        if (clr) begin
            seg_or <= 7'h00;
            rd_cnt <= 0;
            l_cnt <= 0;
            chg_cnt <= 0;
            idx <= 2'h0;
        end else begin
            seg_or <= seg_or | seg;
            if (seg != last) chg_cnt <= chg_cnt + 1;
            if (fresh && seg == DSD_SEG_L) l_cnt <= l_cnt + 1;
            // E opens a reading, then tens and ones follow
            if (fresh && seg == DSD_SEG_E) begin
                idx <= 2'h1;
            end else if (fresh && idx == 2'h1) begin
                tens <= seg;
                idx <= 2'h2;
            end else if (fresh && idx == 2'h2) begin
                ones <= seg;
                idx <= 2'h0;
                rd_cnt <= rd_cnt + 1;
            end
        end
    end
endmodule // dsd_operator_model
`default_nettype wire

// ---- verification/tb_drive_status_display_sequencer.sv ----
// testbench for the status display sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_drive_status_display_sequencer;
    import dsd_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic pwr = 1'b1;
    dsd_variant_t var_sel = DSD_VAR_BASE;
    logic ovt = 1'b0;
    dsd_fault_in_t fi = '0;
    logic fclr = 1'b0;
    logic clr = 1'b0;
    logic [6:0] seg, seg_or, tens, ones;
    logic restr, fact;
    logic [7:0] fcode;
    int rd_cnt, l_cnt, chg_cnt;
    int num_errors = 0;
    int n_checks = 0;

    // short display counts keep the run brief
    dsd_status_display #(.STEP_CYC(4), .BLINK_CYC(8)) dsd_status_display_inst (
        .clk(clk), .srst(srst), .logic_pwr(pwr), .variant(var_sel),
        .overtravel(ovt), .fault_in(fi), .fault_clear(fclr), .seg(seg),
        .motion_restrict(restr), .fault_active(fact), .fault_code(fcode));
    dsd_operator_model dsd_operator_model_inst (
        .clk(clk), .clr(clr), .seg(seg), .seg_or(seg_or), .tens(tens),
        .ones(ones), .rd_cnt(rd_cnt), .l_cnt(l_cnt), .chg_cnt(chg_cnt));

    always #25 clk = ~clk;

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // restart the operator reading
    task automatic rd_clr;
        clr = 1'b1;
        wt(1);
        clr = 1'b0;
    endtask

    task automatic t_ready(input dsd_variant_t v, input logic [6:0] pat);
        var_sel = v;
        wt(3);
        rd_clr();
        wt(60);
        chk(seg_or === pat, "ready pattern");
        chk((v == DSD_VAR_FIBER) == (chg_cnt <= 1), "steadiness");
        $display("done ready %0d", v);
    endtask

    task automatic t_power;
        pwr = 1'b0;
        wt(3);
        chk(seg === DSD_SEG_BLANK, "display lit without power");
        pwr = 1'b1;
        $display("done power");
    endtask

    task automatic t_ovt;
        ovt = 1'b1;
        rd_clr();
        wt(40);
        chk(restr === 1'b1, "no restriction");
        chk(l_cnt >= 2, "L not blinking");
        ovt = 1'b0;
        wt(3);
        chk(restr === 1'b0, "restriction stuck");
        $display("done overtravel");
    endtask

    // fault shown with overtravel held too; it must win
    task automatic t_fault(input logic [7:0] code, input logic [6:0] dig);
        wt(5);
        ovt = 1'b1;
        rd_clr();
        // a reading may start up to one sequence late, so allow three
        wt(150);
        chk(fact === 1'b1 && fcode === code, "fault code");
        chk(rd_cnt >= 2, "sequence not repeated");
        chk(tens === 7'h3F && ones === dig, "digits read");
        chk(l_cnt == 0, "L shown over fault");
        ovt = 1'b0;
        $display("done fault %0h", code);
    endtask

    // drop the cause, clear, and the sequence must stop
    task automatic t_clear;
        fi = '0;
        wt(2);
        fclr = 1'b1;
        wt(3);
        fclr = 1'b0;
        wt(3);
        chk(fact === 1'b0, "fault not cleared");
        rd_clr();
        wt(60);
        chk(rd_cnt == 0, "sequence after clear");
        $display("done clear");
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog: the tests need under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        wt(10);
        srst = 1'b0;
        t_ready(DSD_VAR_BASE, 7'h3F);
        t_ready(DSD_VAR_FIELDBUS, 7'h7F);
        t_ready(DSD_VAR_FIBER, DSD_SEG_4);
        t_power();
        t_ovt();
        // feedback velocity past the limit raises nothing while rollover is off
        fi.half_cycle = 16'h0064;
        fi.vel_cmd = 16'h0064;
        fi.vel_fb = 16'h0065;
        wt(5);
        chk(fact === 1'b0, "fault without rollover");
        fi.rollover_en = 1'b1;
        t_fault(DSD_CODE_E02, 7'h5B);
        t_clear();
        fi.abs_fb = 1'b1;
        fi.rev_from_home = 16'h07FF;
        wt(5);
        chk(fact === 1'b0, "fault at travel limit");
        fi.rev_from_home = 16'h0800;
        t_fault(DSD_CODE_E03, 7'h4F);
        t_clear();
        fi.abs_fb = 1'b1;
        fi.nv_wear_over = 1'b1;
        t_fault(DSD_CODE_E01, 7'h06);
        fi = '0;
        fclr = 1'b1;
        wt(3);
        fclr = 1'b0;
        wt(3);
        chk(fact === 1'b1 && fcode === DSD_CODE_E01, "wear fault gone");
        give_verdict();
    end
endmodule // tb_drive_status_display_sequencer
`default_nettype wire
